//--- rtl/tx_setup_regs.sv
// transmit control and memory split registers with fifo pointer bookkeeping
`timescale 1ns/100ps
`default_nettype none
`include "tx_cfg_params.svh"

module tx_setup_regs
  import tx_cfg_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        bus_cs,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  output logic      [31:0] bus_rdata,
  input  wire logic        crossover_auto_strap,
  input  wire logic        phy_mdix_override,
  input  wire logic        phy_mdix_value,
  input  wire logic        tx_data_push,
  input  wire logic        tx_data_push_last,
  input  wire logic        tx_head_last,
  input  wire logic        mac_ready,
  input  wire logic        tx_stat_pop,
  output logic             tx_data_pop,
  output logic      [11:0] tx_data_wr_addr,
  output logic      [11:0] tx_data_rd_addr,
  output logic             tx_data_full,
  output logic      [11:0] tx_data_capacity,
  output logic             tx_stat_push,
  output logic      [6:0]  tx_stat_wr_addr,
  output logic      [6:0]  tx_stat_rd_addr,
  output logic             tx_stat_full,
  output logic      [7:0]  tx_stat_used,
  output logic      [15:0] rx_pool_bytes,
  output logic             tx_underrun,
  output logic             mac_sending
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // data fifo size in dwords; the pool is held inside the legal span
  function automatic logic [11:0] data_cap(input logic [3:0] pool);
    logic [3:0] p;
    p = pool;
    if (p < `POOL_MIN) begin
      p = `POOL_MIN;
    end
    if (p > `POOL_MAX) begin
      p = `POOL_MAX;
    end
    return {p, 8'h00} - {4'h0, `STAT_DWORDS};
  endfunction

  // pointer step with wrap at the current size
  // a pool shrink can leave a pointer past the end; it then wraps to zero
  function automatic logic [11:0] wrap_inc(input logic [11:0] ptr, input logic [11:0] cap);
    logic [11:0] n;
    n = ptr + 12'h001;
    if (n >= cap) begin
      n = 12'h000;
    end
    return n;
  endfunction

  // ---------------------------------------------------------------
  // state and working nets
  // ---------------------------------------------------------------
  regs_t       cur_r;
  regs_t       cur_nxt;
  logic [11:0] cap;
  logic [3:0]  pool_eff;
  logic        wr_tc;
  logic        wr_hs;
  logic        rd_hit;
  logic        strap_bit;
  logic        push_ok;
  logic        pop_ok;
  logic        spush_ok;
  logic        spop_ok;
  logic [31:0] tc_view;
  logic [31:0] hs_view;

  // bundle toward the transmit engine
  tx_engine_if eng ();

  // engine owns the start decision and the halt handshake
  tx_engine u_engine (
    .mclk (mclk),
    .nrst (nrst),
    .eng  (eng)
  );

  // ---------------------------------------------------------------
  // engine hookup
  // ---------------------------------------------------------------
  // control bits from the bank registers; halt and tx_on are also cleared by the engine's halted pulse
  assign eng.tx_on     = cur_r.tx_on;
  assign eng.halt_req  = cur_r.halt;
  assign eng.allow     = cur_r.allow;
  assign eng.whole     = cur_r.whole;
  assign eng.rate      = cur_r.rate;
  assign eng.level     = cur_r.level;

  // fifo occupancy seen by the start decision
  assign eng.data_used = cur_r.d_used;
  assign eng.frames    = cur_r.frames;

  // pause source and far-side mac signals
  assign eng.stat_full = tx_stat_full;
  assign eng.head_last = tx_head_last;
  assign eng.mac_ready = mac_ready;

  // ---------------------------------------------------------------
  // decode and fifo qualifiers
  // ---------------------------------------------------------------
  // data fifo sizing from the pool field
  assign cap      = data_cap(cur_r.pool);
  assign pool_eff = cap[11:8] + 4'h1;

  // bus strobes, one per cycle of select
  assign wr_tc    = bus_cs && bus_wr && (bus_addr == `TRANSMIT_CONTROL_OFS);
  assign wr_hs    = bus_cs && bus_wr && (bus_addr == `HARDWARE_SETUP_OFS);
  assign rd_hit   = bus_cs && bus_rd;

  // pushes and pops of each fifo are dropped while its own flush is pending
  assign push_ok  = tx_data_push && !tx_data_full && !cur_r.dflush;
  assign pop_ok   = eng.pop && !cur_r.dflush;
  assign spush_ok = eng.stat_push && !tx_stat_full && !cur_r.sflush;
  assign spop_ok  = tx_stat_pop && (cur_r.s_used != 8'h00) && !cur_r.sflush;

  // strap readback unless the phy override is active
  assign strap_bit = phy_mdix_override ? phy_mdix_value : cur_r.strap;

  // read views; reserved positions stay zero
  always_comb begin
    tc_view                     = 32'h0000_0000;
    tc_view[`TC_STAT_FLUSH_BIT] = cur_r.sflush;
    tc_view[`TC_DATA_FLUSH_BIT] = cur_r.dflush;
    tc_view[`TC_OVR_ALLOW_BIT]  = cur_r.allow;
    tc_view[`TC_TX_ON_BIT]      = cur_r.tx_on;
    tc_view[`TC_HALT_BIT]       = cur_r.halt;
    hs_view                     = 32'h0000_0000;
    hs_view[`HS_STRAP_BIT]      = strap_bit;
    hs_view[`HS_RATE_BIT]       = cur_r.rate;
    hs_view[`HS_WHOLE_BIT]      = cur_r.whole;
    hs_view[`HS_POOL_HI:`HS_POOL_LO]   = cur_r.pool;
    hs_view[`HS_LEVEL_HI:`HS_LEVEL_LO] = cur_r.level;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    cur_nxt = cur_r;

    // strap synchroniser and one capture after reset release
    cur_nxt.strap_s1 = crossover_auto_strap;
    cur_nxt.strap_s2 = cur_r.strap_s1;
    if (cur_r.cap_cnt != 2'h3) begin
      cur_nxt.cap_cnt = cur_r.cap_cnt + 2'h1;
    end
    if (cur_r.cap_cnt == `STRAP_SETTLE) begin
      cur_nxt.strap = cur_r.strap_s2;
    end

    // hardware clears first; host writes below win, except halt, which a write cannot clear while it is still set
    if (eng.halted) begin
      cur_nxt.halt  = 1'b0;
      cur_nxt.tx_on = 1'b0;
    end
    cur_nxt.sflush = 1'b0;
    cur_nxt.dflush = 1'b0;

    // transmit_control write
    if (wr_tc) begin
      cur_nxt.allow = bus_wdata[`TC_OVR_ALLOW_BIT];
      cur_nxt.tx_on = bus_wdata[`TC_TX_ON_BIT];
      if (!cur_r.halt) begin
        cur_nxt.halt = bus_wdata[`TC_HALT_BIT];
      end
      if (bus_wdata[`TC_STAT_FLUSH_BIT]) begin
        cur_nxt.sflush = 1'b1;
      end
      if (bus_wdata[`TC_DATA_FLUSH_BIT]) begin
        cur_nxt.dflush = 1'b1;
      end
    end

    // hardware_setup write; bit 24 is read-only
    if (wr_hs) begin
      cur_nxt.rate  = bus_wdata[`HS_RATE_BIT];
      cur_nxt.whole = bus_wdata[`HS_WHOLE_BIT];
      cur_nxt.pool  = bus_wdata[`HS_POOL_HI:`HS_POOL_LO];
      cur_nxt.level = bus_wdata[`HS_LEVEL_HI:`HS_LEVEL_LO];
    end

    // data fifo pointers, counts and complete-frame tally
    if (cur_r.dflush) begin
      cur_nxt.d_wptr = 12'h000;
      cur_nxt.d_rptr = 12'h000;
      cur_nxt.d_used = 12'h000;
      cur_nxt.frames = 12'h000;
    end else begin
      if (push_ok) begin
        cur_nxt.d_wptr = wrap_inc(cur_r.d_wptr, cap);
      end
      if (pop_ok) begin
        cur_nxt.d_rptr = wrap_inc(cur_r.d_rptr, cap);
      end
      cur_nxt.d_used = cur_r.d_used + {11'h000, push_ok} - {11'h000, pop_ok};
      cur_nxt.frames = cur_r.frames + {11'h000, push_ok && tx_data_push_last} -
                       {11'h000, pop_ok && tx_head_last && cur_r.frames != 12'h000};
    end

    // status fifo pointers
    if (cur_r.sflush) begin
      cur_nxt.s_wptr = 7'h00;
      cur_nxt.s_rptr = 7'h00;
      cur_nxt.s_used = 8'h00;
    end else begin
      if (spush_ok) begin
        cur_nxt.s_wptr = cur_r.s_wptr + 7'h01;
      end
      if (spop_ok) begin
        cur_nxt.s_rptr = cur_r.s_rptr + 7'h01;
      end
      cur_nxt.s_used = cur_r.s_used + {7'h00, spush_ok} - {7'h00, spop_ok};
    end

    // registered read data, zero for unmapped offsets
    if (rd_hit) begin
      case (bus_addr)
        `TRANSMIT_CONTROL_OFS: cur_nxt.rdata = tc_view;
        `HARDWARE_SETUP_OFS:   cur_nxt.rdata = hs_view;
        default:               cur_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      // pool returns to five kilobytes, everything else to zero
      cur_r       <= '0;
      cur_r.pool  <= `POOL_RESET;
      cur_r.level <= `LEVEL_RESET;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // read data and data fifo pointers
  assign bus_rdata        = cur_r.rdata;
  assign tx_data_pop      = pop_ok;
  assign tx_data_wr_addr  = cur_r.d_wptr;
  assign tx_data_rd_addr  = cur_r.d_rptr;
  assign tx_data_full     = (cur_r.d_used >= cap);
  assign tx_data_capacity = cap;

  // status fifo side
  assign tx_stat_push     = spush_ok;
  assign tx_stat_wr_addr  = cur_r.s_wptr;
  assign tx_stat_rd_addr  = cur_r.s_rptr;
  // full flag feeds the interrupt path independent of the allow bit
  assign tx_stat_full     = (cur_r.s_used == `STAT_DWORDS);
  assign tx_stat_used     = cur_r.s_used;

  // receive side gets what the transmit pool leaves
  assign rx_pool_bytes    = `TOTAL_BYTES - {2'b00, pool_eff, 10'h000};

  // engine events passed straight out
  assign tx_underrun      = eng.underrun;
  assign mac_sending      = eng.sending;

endmodule

`default_nettype wire

//--- rtl/tx_cfg_params.svh
// offsets, field positions, reset values and sizing constants of the transmit setup registers
`ifndef TX_CFG_PARAMS_SVH
`define TX_CFG_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define TRANSMIT_CONTROL_OFS 8'h70
`define HARDWARE_SETUP_OFS   8'h74

// ---------------------------------------------------------------
// transmit_control fields
// ---------------------------------------------------------------
`define TC_STAT_FLUSH_BIT 15
`define TC_DATA_FLUSH_BIT 14
`define TC_OVR_ALLOW_BIT  2
`define TC_TX_ON_BIT      1
`define TC_HALT_BIT       0

// ---------------------------------------------------------------
// hardware_setup fields and reset values
// ---------------------------------------------------------------
`define HS_STRAP_BIT      24
`define HS_RATE_BIT       21
`define HS_WHOLE_BIT      20
`define HS_POOL_HI        19
`define HS_POOL_LO        16
`define HS_LEVEL_HI       13
`define HS_LEVEL_LO       12
`define POOL_RESET        4'h5
`define POOL_MIN          4'h2
`define POOL_MAX          4'he
`define LEVEL_RESET       2'h0

// ---------------------------------------------------------------
// memory split (bytes and dwords), start thresholds (dwords) and strap settle count
// ---------------------------------------------------------------
`define TOTAL_BYTES       16'h4000
`define STAT_BYTES        12'h200
`define KB_DWORDS         12'h100
`define STAT_DWORDS       8'h80
`define THR10_L0          12'h012
`define THR10_L1          12'h018
`define THR10_L2          12'h020
`define THR10_L3          12'h028
`define STRAP_SETTLE      2'h2

`endif

//--- rtl/tx_cfg_pkg.sv
// types shared by the transmit setup register bank and its transmit engine
package tx_cfg_pkg;

  // engine states, gray along idle -> send -> done
  typedef enum logic [1:0] {
    eng_idle = 2'b00,
    eng_send = 2'b01,
    eng_done = 2'b11
  } eng_state_t;

  // all engine state
  typedef struct packed {
    eng_state_t st;
    logic       underrun;
    logic       halted;
    logic       stat_push;
  } engine_t;

  // all register bank state
  typedef struct packed {
    logic        tx_on;
    logic        halt;
    logic        allow;
    logic        sflush;
    logic        dflush;
    logic        rate;
    logic        whole;
    logic [3:0]  pool;
    logic [1:0]  level;
    logic        strap_s1;
    logic        strap_s2;
    logic        strap;
    logic [1:0]  cap_cnt;
    logic [11:0] d_wptr;
    logic [11:0] d_rptr;
    logic [11:0] d_used;
    logic [11:0] frames;
    logic [6:0]  s_wptr;
    logic [6:0]  s_rptr;
    logic [7:0]  s_used;
    logic [31:0] rdata;
  } regs_t;

endpackage

//--- rtl/tx_engine_if.sv
// signals between the register bank and the transmit engine
`timescale 1ns/100ps
`default_nettype none

interface tx_engine_if;
  logic        tx_on;
  logic        halt_req;
  logic        allow;
  logic        whole;
  logic        rate;
  logic [1:0]  level;
  logic [11:0] data_used;
  logic [11:0] frames;
  logic        stat_full;
  logic        head_last;
  logic        mac_ready;
  logic        pop;
  logic        stat_push;
  logic        underrun;
  logic        halted;
  logic        sending;

  modport bank (output tx_on, halt_req, allow, whole, rate, level, data_used, frames, stat_full,
                head_last, mac_ready, input pop, stat_push, underrun, halted, sending);
  modport engine (input tx_on, halt_req, allow, whole, rate, level, data_used, frames, stat_full,
                  head_last, mac_ready, output pop, stat_push, underrun, halted, sending);
endinterface

`default_nettype wire

//--- rtl/tx_engine.sv
// transmit engine: start decision, dword draining, underrun and halt handling
`timescale 1ns/100ps
`default_nettype none
`include "tx_cfg_params.svh"

module tx_engine
  import tx_cfg_pkg::*;
#(
  parameter logic [11:0] THR100_L0 = 12'h040,
  parameter logic [11:0] THR100_L1 = 12'h080,
  parameter logic [11:0] THR100_L2 = 12'h0c0,
  parameter logic [11:0] THR100_L3 = 12'h100
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  tx_engine_if.engine      eng
);

  // ---------------------------------------------------------------
  // threshold lookup
  // ---------------------------------------------------------------
  function automatic logic [11:0] start_level(input logic rate, input logic [1:0] lvl);
    logic [11:0] v;
    v = 12'h000;
    case ({rate, lvl})
      3'b100:  v = `THR10_L0;
      3'b101:  v = `THR10_L1;
      3'b110:  v = `THR10_L2;
      3'b111:  v = `THR10_L3;
      3'b000:  v = THR100_L0;
      3'b001:  v = THR100_L1;
      3'b010:  v = THR100_L2;
      default: v = THR100_L3;
    endcase
    return v;
  endfunction

  engine_t cur_r;
  engine_t cur_nxt;
  logic    stalled;
  logic    ready_start;

  // full status fifo pauses unless overrun is allowed
  assign stalled = eng.stat_full && !eng.allow;
  // whole frame ignores the threshold; early start fires at the level
  assign ready_start = eng.whole ? (eng.frames != 12'h000) :
                       ((eng.frames != 12'h000) ||
                        (eng.data_used >= start_level(eng.rate, eng.level)));
  assign eng.pop       = (cur_r.st == eng_send) && eng.mac_ready && !stalled &&
                         (eng.data_used != 12'h000);
  assign eng.stat_push = cur_r.stat_push;
  assign eng.underrun  = cur_r.underrun;
  assign eng.halted    = cur_r.halted;
  assign eng.sending   = (cur_r.st == eng_send);

  // next state
  always_comb begin
    cur_nxt           = cur_r;
    cur_nxt.underrun  = 1'b0;
    cur_nxt.halted    = 1'b0;
    cur_nxt.stat_push = 1'b0;
    case (cur_r.st)
      eng_idle: begin
        if (eng.halt_req) begin
          cur_nxt.halted = 1'b1;
        end else if (eng.tx_on && ready_start && !stalled) begin
          cur_nxt.st = eng_send;
        end
      end
      eng_send: begin
        if (eng.pop && eng.head_last) begin
          cur_nxt.st = eng_done;
        end else if (eng.mac_ready && !stalled && eng.data_used == 12'h000) begin
          cur_nxt.underrun = 1'b1;
          cur_nxt.st       = eng_done;
        end
      end
      eng_done: begin
        cur_nxt.stat_push = 1'b1;
        cur_nxt.st        = eng_idle;
      end
      default: begin
        cur_nxt.st = eng_idle;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cur_r <= '{st: eng_idle, underrun: 1'b0, halted: 1'b0, stat_push: 1'b0};
    end else begin
      cur_r <= cur_nxt;
    end
  end

endmodule

`default_nettype wire

//--- test/tx_setup_regs_monitor.sv
// concurrent checks on the transmit setup register bank ports
`timescale 1ns/100ps
`default_nettype none
`include "tx_cfg_params.svh"

module tx_setup_monitor (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        bus_cs,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic [31:0] bus_rdata,
  input  wire logic        mac_ready,
  input  wire logic        tx_data_pop,
  input  wire logic [11:0] tx_data_wr_addr,
  input  wire logic [11:0] tx_data_rd_addr,
  input  wire logic [11:0] tx_data_capacity,
  input  wire logic [6:0]  tx_stat_wr_addr,
  input  wire logic [6:0]  tx_stat_rd_addr,
  input  wire logic        tx_stat_full,
  input  wire logic [7:0]  tx_stat_used,
  input  wire logic [15:0] rx_pool_bytes,
  input  wire logic        tx_underrun,
  input  wire logic        mac_sending
);
  logic       wr_tc;
  logic       wr_hs;
  logic [3:0] pool_h;
  logic [3:0] pool_c;
  logic       allow_h;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // shadow of the written pool size and overrun allow bit
  assign wr_tc = bus_cs && bus_wr && bus_addr == `TRANSMIT_CONTROL_OFS;
  assign wr_hs = bus_cs && bus_wr && bus_addr == `HARDWARE_SETUP_OFS;
  assign pool_c = (pool_h < 4'h2) ? 4'h2 : ((pool_h > 4'he) ? 4'he : pool_h);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pool_h  <= 4'h5;
      allow_h <= 1'b0;
    end else begin
      if (wr_hs) pool_h <= bus_wdata[19:16];
      if (wr_tc) allow_h <= bus_wdata[2];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  stat_flush_a: assert property (wr_tc && bus_wdata[15] |-> ##2
    tx_stat_wr_addr == 7'h00 && tx_stat_rd_addr == 7'h00) else $error("status flush left pointers");
  data_flush_a: assert property (wr_tc && bus_wdata[14] |-> ##2
    tx_data_wr_addr == 12'h000 && tx_data_rd_addr == 12'h000) else $error("data flush left pointers");
  full_pause_a: assert property (tx_stat_full && !allow_h |-> !tx_data_pop)
    else $error("data popped while status full");
  full_flag_a: assert property (tx_stat_full == (tx_stat_used == 8'h80))
    else $error("status full flag wrong");
  pop_cause_a: assert property (tx_data_pop |-> mac_ready && mac_sending)
    else $error("pop outside send");
  tx_size_a: assert property (tx_data_capacity == {pool_c, 8'h00} - 12'h080)
    else $error("data capacity wrong");
  rx_size_a: assert property (rx_pool_bytes == 16'h4000 - {2'h0, pool_c, 10'h000})
    else $error("receive pool wrong");
  underrun_pulse_a: assert property (tx_underrun |-> $past(mac_sending) && !mac_sending ##1 !tx_underrun)
    else $error("underrun pulse wrong");
  tc_rsvd_a: assert property (bus_cs && bus_rd && bus_addr == `TRANSMIT_CONTROL_OFS |=>
    bus_rdata[31:16] == 16'h0000 && bus_rdata[13:3] == 11'h000) else $error("control reserved bits set");
  hs_rsvd_a: assert property (bus_cs && bus_rd && bus_addr == `HARDWARE_SETUP_OFS |=>
    bus_rdata[31:25] == 7'h00 && bus_rdata[23:22] == 2'h0 && bus_rdata[15:14] == 2'h0
    && bus_rdata[11:0] == 12'h000) else $error("setup reserved bits set");

  // main scenarios reached
  flush_c: cover property (wr_tc && bus_wdata[15]);
  underrun_c: cover property (tx_underrun);
  pause_c: cover property (tx_stat_full && !allow_h ##1 tx_stat_full);
endmodule

bind tx_setup_regs tx_setup_monitor mon (.mclk, .nrst, .bus_cs, .bus_wr, .bus_rd, .bus_addr, .bus_wdata,
  .bus_rdata, .mac_ready, .tx_data_pop, .tx_data_wr_addr, .tx_data_rd_addr, .tx_data_capacity,
  .tx_stat_wr_addr, .tx_stat_rd_addr, .tx_stat_full, .tx_stat_used, .rx_pool_bytes, .tx_underrun,
  .mac_sending);

`default_nettype wire

//--- test/tx_far_side.sv
// behavioural host data writer and mac taker feeding the transmit fifo
`timescale 1ns/100ps
`default_nettype none

module tx_far_side (
  input  wire logic        mclk,
  input  wire logic        stall,
  input  wire logic        tx_data_full,
  input  wire logic [11:0] tx_data_wr_addr,
  input  wire logic [11:0] tx_data_rd_addr,
  output logic             tx_data_push,
  output logic             tx_data_push_last,
  output logic             tx_head_last,
  output logic             mac_ready,
  output logic             tx_stat_pop
);
  logic last_mem [4096];

  // mac takes a dword every cycle unless stalled
  assign mac_ready = !stall;
  assign tx_stat_pop = 1'b0;
  assign tx_head_last = last_mem[tx_data_rd_addr];

  initial begin
    tx_data_push = 1'b0;
    tx_data_push_last = 1'b0;
    for (int i = 0; i < 4096; i++) last_mem[i] = 1'b0;
  end

  // remember the frame end flag of each accepted dword
  always @(posedge mclk) begin
    if (tx_data_push && !tx_data_full) last_mem[tx_data_wr_addr] <= tx_data_push_last;
  end

  // one dword per cycle, frame end flagged on the final one when asked
  task automatic push_frame(input int n, input bit fin);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      tx_data_push = !tx_data_full;
      tx_data_push_last = fin && (i == n - 1);
    end
    @(negedge mclk);
    tx_data_push = 1'b0;
    tx_data_push_last = 1'b0;
  endtask
endmodule

`default_nettype wire

//--- test/tx_config_and_fifo_sizing_tb.sv
// self-checking bench for the transmit setup register bank
`timescale 1ns/100ps
`default_nettype none

module tx_config_and_fifo_sizing_tb;
  import tx_cfg_pkg::*;
  logic mclk, nrst, bus_cs, bus_wr, bus_rd, crossover_auto_strap, phy_mdix_override, phy_mdix_value, stall;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata;
  logic tx_data_push, tx_data_push_last, tx_head_last, mac_ready, tx_stat_pop, tx_data_pop, tx_data_full;
  logic tx_stat_push, tx_stat_full, tx_underrun, mac_sending;
  logic [11:0] tx_data_wr_addr, tx_data_rd_addr, tx_data_capacity;
  logic [6:0] tx_stat_wr_addr, tx_stat_rd_addr;
  logic [7:0] tx_stat_used;
  logic [15:0] rx_pool_bytes;
  int err_total = 0, cmp_count = 0, und_cnt = 0, uc;
  logic [11:0] thr [4] = '{12'h012, 12'h018, 12'h020, 12'h028};

  tx_setup_regs uut (.mclk, .nrst, .bus_cs, .bus_wr, .bus_rd, .bus_addr, .bus_wdata, .bus_rdata,
    .crossover_auto_strap, .phy_mdix_override, .phy_mdix_value, .tx_data_push, .tx_data_push_last,
    .tx_head_last, .mac_ready, .tx_stat_pop, .tx_data_pop, .tx_data_wr_addr, .tx_data_rd_addr,
    .tx_data_full, .tx_data_capacity, .tx_stat_push, .tx_stat_wr_addr, .tx_stat_rd_addr, .tx_stat_full,
    .tx_stat_used, .rx_pool_bytes, .tx_underrun, .mac_sending);
  tx_far_side far (.mclk, .stall, .tx_data_full, .tx_data_wr_addr, .tx_data_rd_addr, .tx_data_push,
    .tx_data_push_last, .tx_head_last, .mac_ready, .tx_stat_pop);

  // clock, underrun pulse counter and hang guard
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(negedge mclk) if (tx_underrun === 1'b1) und_cnt++;
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // bus and compare helpers
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge mclk);
    bus_cs = 1'b1;
    bus_wr = 1'b1;
    bus_addr = a;
    bus_wdata = d;
    @(negedge mclk);
    bus_cs = 1'b0;
    bus_wr = 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(negedge mclk);
    bus_cs = 1'b1;
    bus_rd = 1'b1;
    bus_addr = a;
    @(negedge mclk);
    bus_cs = 1'b0;
    bus_rd = 1'b0;
    chk(bus_rdata, exp);
  endtask
  task automatic wait_send(input logic lvl, input int lim);
    for (int n = 0; n < lim && mac_sending !== lvl; n++) @(negedge mclk);
    chk({31'h0, mac_sending}, {31'h0, lvl});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_strap;
    rchk(8'h70, 32'h0);
    rchk(8'h74, 32'h01050000);
    phy_mdix_override = 1'b1;
    rchk(8'h74, 32'h00050000);
    phy_mdix_override = 1'b0;
  endtask
  task automatic t_reserved_sizing;
    wr(8'h74, 32'hffffffff);
    rchk(8'h74, 32'h013f3000);
    chk({20'h0, tx_data_capacity}, 32'hd80);
    chk({16'h0, rx_pool_bytes}, 32'h800);
    wr(8'h74, 32'h00020000);
    cyc(1);
    chk({20'h0, tx_data_capacity}, 32'h180);
    chk({16'h0, rx_pool_bytes}, 32'h3800);
    far.push_frame(385, 1'b0);
    chk({31'h0, tx_data_full}, 32'h1);
    wr(8'h70, 32'hffff3ffc);
    rchk(8'h70, 32'h4);
    rchk(8'h78, 32'h0);
    wr(8'h70, 32'h0);
  endtask
  task automatic t_early_start;
    for (int l = 0; l < 4; l++) begin
      wr(8'h70, 32'h4000);
      cyc(2);
      chk({8'h0, tx_data_wr_addr, tx_data_rd_addr}, 32'h0);
      wr(8'h74, 32'h00250000 | (l << 12));
      far.push_frame(int'(thr[l]) - 1, 1'b0);
      wr(8'h70, 32'h2);
      cyc(10);
      chk({31'h0, mac_sending}, 32'h0);
      uc = und_cnt;
      far.push_frame(1, 1'b0);
      wait_send(1'b1, 10);
      for (int n = 0; n < 200 && und_cnt == uc; n++) @(negedge mclk);
      chk(und_cnt, uc + 1);
      wait_send(1'b0, 10);
    end
  endtask
  task automatic t_stat_flush;
    wr(8'h70, 32'h8000);
    cyc(1);
    chk({10'h0, tx_stat_wr_addr, tx_stat_rd_addr, tx_stat_used}, 32'h0);
    rchk(8'h70, 32'h0);
  endtask
  task automatic t_whole_frame;
    wr(8'h74, 32'h00150000);
    wr(8'h70, 32'h2);
    far.push_frame(300, 1'b0);
    cyc(20);
    chk({31'h0, mac_sending}, 32'h0);
    uc = und_cnt;
    far.push_frame(1, 1'b1);
    wait_send(1'b1, 10);
    wait_send(1'b0, 400);
    cyc(4);
    chk(und_cnt, uc);
    chk({20'h0, tx_data_rd_addr}, {20'h0, tx_data_wr_addr});
    chk({24'h0, tx_stat_used}, 32'h1);
  endtask
  task automatic t_halt;
    stall = 1'b1;
    far.push_frame(4, 1'b1);
    wait_send(1'b1, 10);
    wr(8'h70, 32'h3);
    rchk(8'h70, 32'h3);
    wr(8'h70, 32'h2);
    rchk(8'h70, 32'h3);
    stall = 1'b0;
    cyc(20);
    rchk(8'h70, 32'h0);
    chk({20'h0, tx_data_rd_addr}, {20'h0, tx_data_wr_addr});
  endtask
  task automatic t_status_full;
    wr(8'h70, 32'h8002);
    for (int i = 0; i < 128; i++) begin
      far.push_frame(1, 1'b1);
      cyc(6);
    end
    chk({31'h0, tx_stat_full}, 32'h1);
    far.push_frame(1, 1'b1);
    cyc(20);
    chk({31'h0, tx_data_rd_addr == tx_data_wr_addr}, 32'h0);
    wr(8'h70, 32'h6);
    cyc(10);
    chk({20'h0, tx_data_rd_addr}, {20'h0, tx_data_wr_addr});
    chk({31'h0, tx_stat_full}, 32'h1);
  endtask

  task automatic wrap_up;
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    nrst = 1'b0;
    {bus_cs, bus_wr, bus_rd, phy_mdix_override, phy_mdix_value, stall} = '0;
    crossover_auto_strap = 1'b1;
    bus_addr = 8'h0;
    bus_wdata = 32'h0;
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    cyc(6);
    t_reset_strap();
    t_reserved_sizing();
    t_early_start();
    t_stat_flush();
    t_whole_frame();
    t_halt();
    t_status_full();
    wrap_up();
  end
endmodule

`default_nettype wire
